// ==== design/fois_seq.sv ====
// Forced-output instruction fetch and held-sequence control
//
// Operation
// - T1.1: address from counter, start memory cycle, set increment flag.
// - T1.3: clear operands, data register, op field; set fetch-phase flag.
// - T1.4: counter into operand, set bus inhibit, clear channel register.
// - T2.1: route memory word to selection bus, clear increment flag.
// - T2.2: load counter from adder output.
// - T2.3: clear fetch-phase flag and bus inhibit flag.
// - T2.4: bits 11-6 to op field, set decode flag, bits 5-0 to channel.
// - T3.1: clear translator, stop routing word onto selection bus.
// - Translator clear resets all five bits together, in fetch, phase one.
// - T3.2: load op-code bit 0 and channel bits 3-0 into translator.
// - T3.4 phase four: set first hold when forced or related op decoded.
// - T4.3 phase three: set second hold from first hold.
// - Interrupt set on special interrupt, no bootstrap, insert and hold2 set.
// - Special interrupt condition follows the resume-fault flag.
// - Instruction sequences disabled while either hold flag is set.
// - Held: clear translator T2.1; T2.2 set start, release, reload.
// - Held T4.2 set final, clear hold1; T4.3 clear release flag.
// - Second hold cleared at T1.3 of next instruction fetch.
// - Second transfer runs only with dual-channel operation.
// - Starred counter events follow the advance subsequence.
// - Clear instruction-start at T4.1, set instruction flag at T4.2.
// - Sequences held one full main cycle before transfer.
// - Holds kept until output available, then transfer.
// - Resume fault: no output, release hold, decrement counter.
// - Word kind shown only by which acknowledge accompanies it.
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
module fois_seq
	import fois_pkg::*;
(
	input wire logic mclk_in, // Clock, 40 MHz
	input wire logic resetn_in, // Async reset, active low
	input wire logic start_in, // Request instruction fetch
	input wire logic output_avail_in, // Channel output available
	input wire logic resume_fault_in, // Resume fault present
	input wire logic bootstrap_in, // Bootstrap sequence running
	input wire logic insert_in, // Address bus insert flag
	input wire logic dual_chan_in, // Dual-channel mode selected
	input wire logic mem_we_in, // Memory load strobe
	input wire logic [MEM_AW-1:0] mem_waddr_in, // Memory load address
	input wire logic [WORD_W-1:0] mem_wdata_in, // Memory load data
	output logic [PC_W-1:0] pc_out, // Program counter
	output logic [PC_W-1:0] mar_out, // Memory address register
	output logic [OPF_W-1:0] opfield_out, // Operation field
	output logic [CHAN_W-1:0] chan_out, // Channel number register
	output logic [XLT_W-1:0] xlate_out, // First translator bits
	output logic hold1_out, // First hold flag
	output logic hold2_out, // Second hold flag
	output logic int_req_out, // Interrupt request flag
	output logic seq_en_out, // Instruction sequences enabled
	output logic xfer1_start_out, // First transfer start flag
	output logic xfer1_final_out, // First transfer final flag
	output logic xfer2_out, // Second transfer sequence
	output logic ack_od_out, // Output data acknowledge
	output logic ack_ef_out, // External function acknowledge
	output logic [2:0] phase_out // Time-cycle bit 0 and sub-time bits
);
	typedef struct packed {
		fois_state_t st;
		logic [1:0] ph;
		logic [1:0] sub;
		logic [1:0] tcyc;
		logic [PC_W-1:0] pc;
		logic [PC_W-1:0] mar;
		logic [PC_W-1:0] opnd;
		logic [WORD_W-1:0] mdr;
		logic [WORD_W-1:0] selbus;
		logic sel_on;
		logic [OPF_W-1:0] opf;
		logic [CHAN_W-1:0] chan;
		logic [XLT_W-1:0] xlt;
		logic incr;
		logic fetch_phase_flag;
		logic decode_flag;
		logic address_bus_inhibit_flag;
		logic hold1;
		logic hold2;
		logic rel;
		logic int_req;
		logic istart;
		logic instr;
		logic x1s;
		logic x1f;
		logic x2;
		logic ack_od;
		logic ack_ef;
		logic mem_go;
	} fois_regs_t;

	fois_regs_t r;
	fois_regs_t next_r;
	logic [WORD_W-1:0] mem_rdata;

	// Sub-time match
	function automatic logic at(input logic [1:0] tc, input logic [1:0] sb,
		input logic [1:0] c, input logic [1:0] s);
		at = (tc == c) && (sb == s);
	endfunction : at

	function automatic logic is_force(input logic [OPF_W-1:0] f);
		is_force = (f == OP_FORCE_OD) || (f == OP_FORCE_EF) ||
			((f >= OP_REL_LO) && (f <= OP_REL_HI));
	endfunction : is_force

	fois_mem u_mem (
		.mclk_in(mclk_in),
		.we_in(mem_we_in),
		.waddr_in(mem_waddr_in),
		.wdata_in(mem_wdata_in),
		.raddr_in(r.mar[MEM_AW-1:0]),
		.rdata_out(mem_rdata)
	);

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic spec_int;
		spec_int = 1'b0;
		next_r = r;
		next_r.ack_od = 1'b0;
		next_r.ack_ef = 1'b0;
		// Timing chain: sub-time advances each clock, cycle every four
		next_r.sub = r.sub + 2'h1;
		next_r.ph = r.sub + 2'h1;
		if (r.sub == PH4) begin
			next_r.tcyc = r.tcyc + 2'h1;
		end
		spec_int = resume_fault_in;
		case (r.st)
			FOIS_IDLE: begin
				if (start_in && !r.hold1 && !r.hold2 && at(r.tcyc, r.sub, PH4, PH4)) begin
					next_r.st = FOIS_FETCH;
					next_r.mar = '0;
				end
			end
			FOIS_FETCH, FOIS_NEXT: begin
				if (at(r.tcyc, r.sub, PH1, PH1)) begin
					next_r.mar = r.pc;
					next_r.mem_go = 1'b1;
					next_r.incr = 1'b1;
				end
				if (at(r.tcyc, r.sub, PH1, PH3)) begin
					next_r.opnd = '0;
					next_r.mdr = '0;
					next_r.opf = '0;
					next_r.fetch_phase_flag = 1'b1;
					if (r.st == FOIS_NEXT) begin
						next_r.hold2 = 1'b0;
					end
				end
				if (at(r.tcyc, r.sub, PH1, PH4)) begin
					next_r.opnd = r.pc;
					next_r.address_bus_inhibit_flag = 1'b1;
					next_r.chan = '0;
					// Memory word lands after the T1.3 clear
					if (r.mem_go) begin
						next_r.mdr = mem_rdata;
						next_r.mem_go = 1'b0;
					end
				end
				if (at(r.tcyc, r.sub, PH2, PH1)) begin
					next_r.selbus = r.mdr;
					next_r.sel_on = 1'b1;
					next_r.incr = 1'b0;
				end
				if (at(r.tcyc, r.sub, PH2, PH2) && r.incr == 1'b0) begin
					next_r.pc = r.opnd + PC_ONE;
				end
				if (at(r.tcyc, r.sub, PH2, PH3)) begin
					next_r.fetch_phase_flag = 1'b0;
					next_r.address_bus_inhibit_flag = 1'b0;
				end
				if (at(r.tcyc, r.sub, PH2, PH4)) begin
					next_r.opf = r.selbus[OPF_HI:OPF_LO];
					next_r.decode_flag = 1'b1;
					next_r.chan = r.selbus[CHAN_HI:CHAN_LO];
				end
				if (at(r.tcyc, r.sub, PH3, PH1)) begin
					next_r.xlt = '0;
					next_r.sel_on = 1'b0;
					next_r.selbus = '0;
				end
				if (at(r.tcyc, r.sub, PH3, PH2)) begin
					next_r.xlt = {r.opf[0], r.chan[3:0]};
				end
				if (at(r.tcyc, r.sub, PH3, PH4) && is_force(r.opf)) begin
					next_r.hold1 = 1'b1;
				end
				if (at(r.tcyc, r.sub, PH4, PH1)) begin
					next_r.istart = 1'b0;
				end
				if (at(r.tcyc, r.sub, PH4, PH2)) begin
					next_r.instr = 1'b1;
				end
				if (at(r.tcyc, r.sub, PH4, PH3)) begin
					if (r.hold1) begin
						next_r.hold2 = 1'b1;
					end
					if (spec_int && !bootstrap_in && insert_in && r.hold2) begin
						next_r.int_req = 1'b1;
					end
				end
				if (at(r.tcyc, r.sub, PH4, PH4)) begin
					next_r.decode_flag = 1'b0;
					next_r.st = (next_r.hold1 || next_r.hold2) ? FOIS_HELD : FOIS_IDLE;
				end
			end
			FOIS_HELD: begin
				if (at(r.tcyc, r.sub, PH4, PH3) && !r.int_req &&
						spec_int && !bootstrap_in && insert_in && r.hold2) begin
					next_r.int_req = 1'b1;
				end
				if (resume_fault_in && at(r.tcyc, r.sub, PH4, PH4)) begin
					next_r.hold1 = 1'b0;
					next_r.hold2 = 1'b0;
					next_r.pc = r.pc - PC_ONE;
					next_r.st = FOIS_IDLE;
				end else begin
					// Once released, the final steps finish even if the channel drops
					if (output_avail_in && at(r.tcyc, r.sub, PH2, PH1)) begin
						next_r.xlt = '0;
					end
					if (output_avail_in && at(r.tcyc, r.sub, PH2, PH2)) begin
						next_r.x1s = 1'b1;
						next_r.rel = 1'b1;
						next_r.xlt = {r.opf[0], r.chan[3:0]};
					end
					if (at(r.tcyc, r.sub, PH4, PH2) && r.rel) begin
						next_r.x1f = 1'b1;
						next_r.hold1 = 1'b0;
					end
					if (at(r.tcyc, r.sub, PH4, PH3) && !r.hold1 && r.rel) begin
						next_r.rel = 1'b0;
						next_r.st = FOIS_XFER1;
					end
				end
			end
			FOIS_XFER1: begin
				next_r.ack_od = (r.opf == OP_FORCE_OD);
				next_r.ack_ef = (r.opf != OP_FORCE_OD);
				next_r.x1s = 1'b0;
				next_r.x1f = 1'b0;
				next_r.st = dual_chan_in ? FOIS_XFER2 : FOIS_NEXT;
				next_r.x2 = dual_chan_in;
			end
			FOIS_XFER2: begin
				next_r.x2 = 1'b0;
				next_r.st = FOIS_NEXT;
			end
			default: begin
				next_r.st = FOIS_IDLE;
			end
		endcase
		if (r.st == FOIS_NEXT && at(r.tcyc, r.sub, PH1, PH4) && !r.hold2) begin
			next_r.st = FOIS_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	logic seq_en;
	logic [2:0] phase_q;
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			seq_en <= 1'b0;
			phase_q <= 3'h0;
		end else begin
			seq_en <= !(next_r.hold1 || next_r.hold2);
			phase_q <= {next_r.tcyc[0], next_r.sub};
		end
	end

	assign pc_out = r.pc;
	assign mar_out = r.mar;
	assign opfield_out = r.opf;
	assign chan_out = r.chan;
	assign xlate_out = r.xlt;
	assign hold1_out = r.hold1;
	assign hold2_out = r.hold2;
	assign int_req_out = r.int_req;
	assign seq_en_out = seq_en;
	assign xfer1_start_out = r.x1s;
	assign xfer1_final_out = r.x1f;
	assign xfer2_out = r.x2;
	assign ack_od_out = r.ack_od;
	assign ack_ef_out = r.ack_ef;
	assign phase_out = phase_q;

	////////////////////////////////////////////////////////////////////////////
	sequence s_release_done;
		(r.x1f && !r.hold1) ##1 (!r.rel && r.st == FOIS_XFER1);
	endsequence

	property p_release;
		@(posedge mclk_in) disable iff (!resetn_in)
			(r.st == FOIS_HELD && r.rel && at(r.tcyc, r.sub, PH4, PH2)) |=> s_release_done;
	endproperty
	a_release: assert property (p_release) else $error("held release out of order");

	property p_hold12;
		@(posedge mclk_in) disable iff (!resetn_in)
			(r.hold1 && r.st == FOIS_FETCH && at(r.tcyc, r.sub, PH4, PH3)) |=> r.hold2;
	endproperty
	a_hold12: assert property (p_hold12) else $error("hold2 not set");

	property p_xlt_clr;
		@(posedge mclk_in) disable iff (!resetn_in)
			(r.st == FOIS_FETCH && at(r.tcyc, r.sub, PH3, PH1)) |=> (r.xlt == '0);
	endproperty
	a_xlt_clr: assert property (p_xlt_clr) else $error("translator not cleared");

	property p_seq_dis;
		@(posedge mclk_in) disable iff (!resetn_in)
			(r.hold1 || r.hold2) |-> !seq_en;
	endproperty
	a_seq_dis: assert property (p_seq_dis) else $error("sequences not disabled");

	property p_ack;
		@(posedge mclk_in) disable iff (!resetn_in)
			!(r.ack_od && r.ack_ef);
	endproperty
	a_ack: assert property (p_ack) else $error("both acknowledges");

	property p_sub;
		@(posedge mclk_in) disable iff (!resetn_in)
			(r.sub == PH4) |=> (r.sub == PH1) ##1 (r.sub == PH2) ##1 (r.sub == PH3);
	endproperty
	a_sub: assert property (p_sub) else $error("sub-time out of order");

	property p_incr;
		@(posedge mclk_in) disable iff (!resetn_in)
			(r.st == FOIS_FETCH && at(r.tcyc, r.sub, PH1, PH1)) |=> r.incr [*4];
	endproperty
	a_incr: assert property (p_incr) else $error("increment flag lost");

	property p_fetchflag;
		@(posedge mclk_in) disable iff (!resetn_in)
			(r.st == FOIS_FETCH && at(r.tcyc, r.sub, PH1, PH3)) |=>
				r.fetch_phase_flag [*4] ##1 !r.fetch_phase_flag;
	endproperty
	a_fetchflag: assert property (p_fetchflag) else $error("fetch flag timing");

	property p_x2;
		@(posedge mclk_in) disable iff (!resetn_in)
			(r.st == FOIS_XFER1 && !dual_chan_in) |=> !r.x2;
	endproperty
	a_x2: assert property (p_x2) else $error("second transfer without dual");

	property p_rel;
		@(posedge mclk_in) disable iff (!resetn_in)
			(r.st == FOIS_HELD && $rose(r.rel)) |-> ##[1:15] !r.rel;
	endproperty
	a_rel: assert property (p_rel) else $error("release flag stuck");
endmodule : fois_seq

// ==== design/fois_pkg.sv ====
// Package of timing, field and state definitions for the forced-output sequencer
package fois_pkg;
	localparam int WORD_W = 18;
	localparam int PC_W = 16;
	localparam int OPF_W = 6;
	localparam int CHAN_W = 6;
	localparam int XLT_W = 5;
	localparam logic [1:0] PH1 = 2'h0;
	localparam logic [1:0] PH2 = 2'h1;
	localparam logic [1:0] PH3 = 2'h2;
	localparam logic [1:0] PH4 = 2'h3;
	localparam int OPF_HI = 11;
	localparam int OPF_LO = 6;
	localparam int CHAN_HI = 5;
	localparam int CHAN_LO = 0;
	localparam logic [OPF_W-1:0] OP_FORCE_OD = 6'h1a;
	localparam logic [OPF_W-1:0] OP_FORCE_EF = 6'h1b;
	localparam logic [OPF_W-1:0] OP_REL_LO = 6'h20;
	localparam logic [OPF_W-1:0] OP_REL_HI = 6'h27;
	localparam logic [PC_W-1:0] PC_ONE = 16'h0001;
	localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
	localparam int MEM_DEPTH = 16;
	localparam int MEM_AW = 4;
	typedef enum logic [2:0] {
		FOIS_IDLE,
		FOIS_FETCH,
		FOIS_HELD,
		FOIS_XFER1,
		FOIS_XFER2,
		FOIS_NEXT
	} fois_state_t;
endpackage : fois_pkg

// ==== design/fois_mem.sv ====
// Small instruction memory with registered read data
`timescale 1ns/1ps
module fois_mem
	import fois_pkg::*;
(
	input wire logic mclk_in, // Clock
	input wire logic we_in, // Write enable
	input wire logic [MEM_AW-1:0] waddr_in, // Write address
	input wire logic [WORD_W-1:0] wdata_in, // Write data
	input wire logic [MEM_AW-1:0] raddr_in, // Read address
	output logic [WORD_W-1:0] rdata_out // Registered read data
);
	logic [WORD_W-1:0] mem [MEM_DEPTH];

	always_ff @(posedge mclk_in) begin
		if (we_in) begin
			mem[waddr_in] <= wdata_in;
		end
		rdata_out <= mem[raddr_in];
	end
endmodule : fois_mem

// ==== test/fois_chan_model.sv ====
// Channel-side model: output availability and resume fault
`timescale 1ns/1ps
module fois_chan_model
	import fois_pkg::*;
(
	input wire logic mclk_in, // Clock
	input wire logic resetn_in, // Async reset, active low
	input wire logic hold1_in, // First hold flag
	input wire logic [7:0] delay_in, // Cycles until output is free
	input wire logic fault_in, // Present a resume fault
	output logic output_avail_out, // Output available
	output logic resume_fault_out // Resume fault present
);
	logic [7:0] wait_cnt;
	////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wait_cnt <= 8'h00;
			output_avail_out <= 1'b0;
			resume_fault_out <= 1'b0;
		end else begin
			resume_fault_out <= fault_in;
			if (!hold1_in) begin
				wait_cnt <= 8'h00;
				output_avail_out <= 1'b0;
			end else if (wait_cnt < delay_in) begin
				wait_cnt <= wait_cnt + 8'h01;
			end else begin
				// No-resume makes output unavailable
				output_avail_out <= !fault_in;
			end
		end
	end
endmodule : fois_chan_model

// ==== test/tb_fois_seq.sv ====
// Testbench for the forced-output sequencer
`timescale 1ns/1ps
module tb_fois_seq;
	import fois_pkg::*;
	logic mclk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic start_in = 1'b0;
	logic avail, rfault;
	logic bootstrap_in = 1'b0;
	logic insert_in = 1'b1;
	logic dual_chan_in = 1'b0;
	logic mem_we_in = 1'b0;
	logic [MEM_AW-1:0] mem_waddr_in = 4'h0;
	logic [WORD_W-1:0] mem_wdata_in = 18'h00000;
	logic [7:0] delay = 8'h00;
	logic fault = 1'b0;
	logic [PC_W-1:0] pc_out, mar_out;
	logic [OPF_W-1:0] opfield_out;
	logic [CHAN_W-1:0] chan_out;
	logic [XLT_W-1:0] xlate_out;
	logic hold1_out, hold2_out, int_req_out, seq_en_out;
	logic xfer1_start_out, xfer1_final_out, xfer2_out, ack_od_out, ack_ef_out;
	logic [2:0] phase_out;
	int num_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	int n_od = 0;
	int n_ef = 0;
	int n_x2 = 0;
	int exp_pc = 0;
	logic [WORD_W-1:0] prog[$];
	logic [31:0] rnd = 32'hd2aa;
	////////////////////////////////////////////////////////////////
	fois_seq u_fois_seq (.mclk_in(mclk_in), .resetn_in(resetn_in), .start_in(start_in),
		.output_avail_in(avail), .resume_fault_in(rfault), .bootstrap_in(bootstrap_in),
		.insert_in(insert_in), .dual_chan_in(dual_chan_in), .mem_we_in(mem_we_in),
		.mem_waddr_in(mem_waddr_in), .mem_wdata_in(mem_wdata_in), .pc_out(pc_out),
		.mar_out(mar_out), .opfield_out(opfield_out), .chan_out(chan_out),
		.xlate_out(xlate_out), .hold1_out(hold1_out), .hold2_out(hold2_out),
		.int_req_out(int_req_out), .seq_en_out(seq_en_out),
		.xfer1_start_out(xfer1_start_out), .xfer1_final_out(xfer1_final_out),
		.xfer2_out(xfer2_out), .ack_od_out(ack_od_out), .ack_ef_out(ack_ef_out),
		.phase_out(phase_out));
	fois_chan_model u_fois_chan_model (.mclk_in(mclk_in), .resetn_in(resetn_in),
		.hold1_in(hold1_out), .delay_in(delay), .fault_in(fault),
		.output_avail_out(avail), .resume_fault_out(rfault));
	////////////////////////////////////////////////////////////////
	always #12.5 mclk_in = ~mclk_in;
	always @(posedge mclk_in) begin
		cyc++;
		n_od += (ack_od_out === 1'b1);
		n_ef += (ack_ef_out === 1'b1);
		n_x2 += (xfer2_out === 1'b1);
		if (cyc == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic run(input int mode, input logic dual, input logic boot);
		logic [WORD_W-1:0] w;
		logic [5:0] op, ch;
		logic forced;
		int old, n, a0, x0, o0;
		old = exp_pc;
		w = prog[old % MEM_DEPTH];
		op = w[11:6];
		ch = w[5:0];
		forced = op == 6'h1a || op == 6'h1b || (op >= 6'h20 && op <= 6'h27);
		a0 = n_od + n_ef;
		o0 = n_od;
		x0 = n_x2;
		dual_chan_in <= dual;
		bootstrap_in <= boot;
		fault <= (mode == 2);
		delay <= (mode == 1) ? 8'd40 : 8'd0;
		start_in <= 1'b1;
		n = 0;
		while (pc_out !== 16'(old + 1) && n < 100) begin
			@(posedge mclk_in);
			n++;
		end
		start_in <= 1'b0;
		#1;
		chk("mar", mar_out, 32'(old));
		chk("pc", pc_out, 32'(old + 1));
		repeat (4) @(posedge mclk_in);
		#1;
		chk("opfield", opfield_out, op);
		chk("chan", chan_out, ch);
		chk("xlate", xlate_out, {op[0], ch[3:0]});
		exp_pc = old + 1;
		if (forced) begin
			repeat (6) @(posedge mclk_in);
			#1;
			chk("hold1", hold1_out, 1'b1);
			chk("hold2", hold2_out, 1'b1);
			chk("seq_en", seq_en_out, 1'b0);
		end
		if (forced && mode != 2) begin
			if (mode == 1) begin
				repeat (20) @(posedge mclk_in);
				#1;
				chk("late hold", {hold1_out, hold2_out, seq_en_out}, 3'b110);
			end
			n = 0;
			while (hold1_out !== 1'b0 && n < 200) begin
				@(posedge mclk_in);
				#1;
				n++;
			end
			chk("release", {xfer1_start_out, xfer1_final_out, hold1_out, hold2_out},
				4'b1101);
			n = 0;
			while (n_od + n_ef == a0 && n < 200) begin
				@(posedge mclk_in);
				n++;
			end
			repeat (20) @(posedge mclk_in);
			#1;
			chk("acks", n_od + n_ef - a0, 1);
			chk("ack od", n_od - o0, 32'(op == 6'h1a));
			chk("xfer2", n_x2 - x0, 32'(dual));
			chk("done", {xfer1_start_out, xfer1_final_out, hold1_out, hold2_out, seq_en_out},
				5'b00001);
		end else if (forced) begin
			n = 0;
			while (hold2_out !== 1'b0 && n < 100) begin
				@(posedge mclk_in);
				n++;
			end
			#1;
			chk("retry pc", pc_out, 32'(old));
			chk("int", int_req_out, !boot);
			chk("no word", n_od + n_ef - a0, 0);
			chk("released", {hold1_out, seq_en_out}, 2'b01);
			exp_pc = old;
		end else begin
			repeat (6) @(posedge mclk_in);
			#1;
			chk("plain hold", {hold1_out, hold2_out, seq_en_out}, 3'b001);
		end
		$display("test op %h mode %0d done", op, mode);
	endtask : run
	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop
	////////////////////////////////////////////////////////////////
	initial begin
		logic [5:0] ops[8];
		ops = '{6'h1a, 6'h05, 6'h1b, 6'h23, 6'h1a, 6'h27, 6'h20, 6'h3f};
		repeat (12) @(posedge mclk_in);
		resetn_in <= 1'b1;
		foreach (ops[i]) begin
			rnd = lfsr(rnd);
			prog.push_back({rnd[17:12], ops[i], rnd[5:0]});
			mem_we_in <= 1'b1;
			mem_waddr_in <= 4'(i);
			mem_wdata_in <= prog[i];
			@(posedge mclk_in);
		end
		mem_we_in <= 1'b0;
		@(posedge mclk_in);
		run(0, 1'b0, 1'b0);
		run(0, 1'b0, 1'b0);
		run(0, 1'b1, 1'b0);
		run(1, 1'b0, 1'b0);
		run(2, 1'b0, 1'b1);
		run(2, 1'b0, 1'b0);
		run(0, 1'b1, 1'b0);
		run(0, 1'b0, 1'b0);
		run(1, 1'b1, 1'b0);
		run(0, 1'b0, 1'b0);
		report_and_stop();
	end
endmodule : tb_fois_seq
